// *** rtl/aec_seq_pkg.sv ***
// constants for the exposure readback and sequencer setup register bank
`default_nettype none
package aec_seq_pkg;
  // =====================================================================
  // serial frame layout: address, write flag, data, msb first
  localparam int ADDR_W     = 9;
  localparam int DATA_W     = 16;
  localparam int HDR_BITS   = 10;
  localparam int FRAME_BITS = 26;
  localparam int CNT_W      = 5;
  localparam int SYNC_N     = 3;

  // =====================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_COUNT_LOW  = 9'h0B8;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH = 9'h0B9;
  localparam logic [ADDR_W-1:0] OFS_MEAN_LOCK  = 9'h0BA;
  localparam logic [ADDR_W-1:0] OFS_EXPO       = 9'h0BB;
  localparam logic [ADDR_W-1:0] OFS_AMP        = 9'h0BC;
  localparam logic [ADDR_W-1:0] OFS_SPARE_BD   = 9'h0BD;
  localparam logic [ADDR_W-1:0] OFS_SEQ_SETUP  = 9'h0C0;

  // spare read/write words and their reset values
  localparam int SPARE_N = 3;
  localparam int SPARE_W = 10;
  localparam logic [ADDR_W-1:0]  SPARE_OFS [SPARE_N] = '{9'h0B3, 9'h0B4, 9'h0B5};
  localparam logic [SPARE_W-1:0] SPARE_RST [SPARE_N] = '{10'h0AA, 10'h100, 10'h155};

  // =====================================================================
  // field layout
  localparam int COUNT_W      = 19;
  localparam int COUNT_LOW_W  = 16;
  localparam int COUNT_HIGH_W = 3;
  localparam int MEAN_W       = 10;
  localparam int LOCK_BIT     = 12;
  localparam int EXPO_W       = 16;
  localparam int AMP_W        = 2;
  localparam int AMP_A_LSB    = 0;
  localparam int AMP_B_LSB    = 2;
  localparam int DGAIN_LSB    = 4;
  localparam int DGAIN_W      = 12;

  localparam int SEQ_ENABLE_BIT  = 0;
  localparam int SEQ_ROLLING_BIT = 1;
  localparam int SEQ_TRIG_BIT    = 4;
  localparam int SEQ_SLAVE_BIT   = 5;
  localparam logic [DATA_W-1:0] RST_SEQ_SETUP = 16'h0000;
endpackage
`default_nettype wire

// *** rtl/cfg_port_if.sv ***
// interface between the serial frame engine and the register bank
`timescale 1ns/1ps
`default_nettype none
interface cfg_port_if;
  import aec_seq_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_en;
  logic              rd_req;
  logic [DATA_W-1:0] rd_data;

  modport engine (output addr, output wr_data, output wr_en, output rd_req, input rd_data);
  modport bank   (input addr, input wr_data, input wr_en, input rd_req, output rd_data);
endinterface
`default_nettype wire

// *** rtl/spi_frame_engine.sv ***
// serial configuration port: pin sync, frame shifter and readback shifter
`timescale 1ns/1ps
`default_nettype none
module spi_frame_engine
  import aec_seq_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  input  wire logic   spi_sclk,
  input  wire logic   spi_ss_n,
  input  wire logic   spi_mosi,
  output logic        spi_miso,
  output logic        spi_miso_oe_n,
  cfg_port_if.engine  port
);
  localparam int PIN_SCLK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SS_N = 2;
  localparam logic [SYNC_N-1:0] PIN_RST = 3'h4;

  logic [SYNC_N-1:0] pins;
  logic [SYNC_N-1:0] pin_f;
  logic              sclk_d;
  logic [CNT_W-1:0]  bit_cnt;
  logic [FRAME_BITS-1:0] shift_in;
  logic [DATA_W-1:0] out_sh;
  logic              load_q;
  logic              rise;
  logic              fall;
  logic              sel;

  assign pins = {spi_ss_n, spi_mosi, spi_sclk};

  // =====================================================================
  // three-stage sync per pin, change taken when stages two and three agree
  for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
    logic [SYNC_N-1:0] st;
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        st       <= {SYNC_N{PIN_RST[i]}};
        pin_f[i] <= PIN_RST[i];
      end else begin
        st <= {st[SYNC_N-2:0], pins[i]};
        if (st[1] == st[2]) begin
          pin_f[i] <= st[2];
        end
      end
    end
  end

  // clock edge detect on the filtered level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= pin_f[PIN_SCLK];
    end
  end
  assign rise = pin_f[PIN_SCLK] & ~sclk_d;
  assign fall = ~pin_f[PIN_SCLK] & sclk_d;
  assign sel  = ~pin_f[PIN_SS_N];

  // =====================================================================
  // frame shifter; extra bits past a full frame are ignored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt  <= '0;
      shift_in <= '0;
    end else if (!sel) begin
      bit_cnt <= '0;
    end else if (rise && bit_cnt < CNT_W'(FRAME_BITS)) begin
      shift_in <= {shift_in[FRAME_BITS-2:0], pin_f[PIN_MOSI]};
      bit_cnt  <= bit_cnt + CNT_W'(1);
    end
  end

  // request strobes: read after the header, write after the last data bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port.rd_req  <= 1'b0;
      port.wr_en   <= 1'b0;
      port.addr    <= '0;
      port.wr_data <= '0;
    end else begin
      port.rd_req <= sel && rise && bit_cnt == CNT_W'(HDR_BITS - 1) && !pin_f[PIN_MOSI];
      port.wr_en  <= sel && rise && bit_cnt == CNT_W'(FRAME_BITS - 1) && shift_in[FRAME_BITS - 1 - HDR_BITS];
      if (sel && rise && bit_cnt == CNT_W'(HDR_BITS - 1)) begin
        port.addr <= shift_in[ADDR_W-1:0];
      end
      if (sel && rise && bit_cnt == CNT_W'(FRAME_BITS - 1)) begin
        port.wr_data <= {shift_in[DATA_W-2:0], pin_f[PIN_MOSI]};
      end
    end
  end

  // =====================================================================
  // readback shifter, new bit on each falling edge of the data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_q        <= 1'b0;
      out_sh        <= '0;
      spi_miso      <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      load_q        <= port.rd_req;
      spi_miso_oe_n <= ~sel; // released while deselected
      if (!sel) begin
        spi_miso <= 1'b0;
      end else if (load_q) begin
        out_sh <= port.rd_data;
      end else if (fall && bit_cnt >= CNT_W'(HDR_BITS)) begin
        spi_miso <= out_sh[DATA_W-1];
        out_sh   <= {out_sh[DATA_W-2:0], 1'b0};
      end
    end
  end
endmodule // spi_frame_engine
`default_nettype wire

// *** rtl/aec_seq_regbank.sv ***
// exposure loop readback and readout sequencer setup behind the serial port
`timescale 1ns/1ps
`default_nettype none
module aec_seq_regbank
  import aec_seq_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               spi_sclk,
  input  wire logic               spi_ss_n,
  input  wire logic               spi_mosi,
  output logic                    spi_miso,
  output logic                    spi_miso_oe_n,
  input  wire logic [COUNT_W-1:0] aec_sample_count,
  input  wire logic [MEAN_W-1:0]  aec_mean,
  input  wire logic               aec_locked,
  input  wire logic [EXPO_W-1:0]  aec_exposure,
  input  wire logic [AMP_W-1:0]   analog_amp_step_a,
  input  wire logic [AMP_W-1:0]   analog_amp_step_b,
  input  wire logic [DGAIN_W-1:0] aec_digital_gain,
  output logic                    seq_enable,
  output logic                    rolling_shutter,
  output logic                    triggered_mode,
  output logic                    slave_mode
);
  cfg_port_if port ();

  logic [COUNT_W-1:0] snap_count;
  logic [MEAN_W-1:0]  snap_mean;
  logic               snap_lock;
  logic [EXPO_W-1:0]  snap_expo;
  logic [AMP_W-1:0]   snap_amp_a;
  logic [AMP_W-1:0]   snap_amp_b;
  logic [DGAIN_W-1:0] snap_dgain;
  logic [SPARE_W-1:0] spare [SPARE_N];
  logic               cfg_enable;
  logic               cfg_rolling;
  logic               cfg_trig;
  logic               cfg_slave;
  logic [DATA_W-1:0]  next_rd_data;
  logic               seq_wr;

  // =====================================================================
  // serial port
  spi_frame_engine u_engine (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .spi_sclk      (spi_sclk),
    .spi_ss_n      (spi_ss_n),
    .spi_mosi      (spi_mosi),
    .spi_miso      (spi_miso),
    .spi_miso_oe_n (spi_miso_oe_n),
    .port          (port)
  );

  // =====================================================================
  // readback snapshot, fed only by the exposure loop, never by the host
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_count <= '0;
      snap_mean  <= '0;
      snap_lock  <= 1'b0;
      snap_expo  <= '0;
      snap_amp_a <= '0;
      snap_amp_b <= '0;
      snap_dgain <= '0;
    end else begin
      snap_count <= aec_sample_count;
      snap_mean  <= aec_mean;
      snap_lock  <= aec_locked;
      snap_expo  <= aec_exposure;
      snap_amp_a <= analog_amp_step_a;
      snap_amp_b <= analog_amp_step_b;
      snap_dgain <= aec_digital_gain;
    end
  end

  // =====================================================================
  // spare words, plain storage
  for (genvar i = 0; i < SPARE_N; i++) begin : g_spare
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        spare[i] <= SPARE_RST[i];
      end else if (port.wr_en && port.addr == SPARE_OFS[i]) begin
        spare[i] <= port.wr_data[SPARE_W-1:0];
      end
    end
  end

  // =====================================================================
  // sequencer setup word; only its own offset writes it
  assign seq_wr = port.wr_en && port.addr == OFS_SEQ_SETUP;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_enable  <= RST_SEQ_SETUP[SEQ_ENABLE_BIT];
      cfg_rolling <= RST_SEQ_SETUP[SEQ_ROLLING_BIT];
      cfg_trig    <= RST_SEQ_SETUP[SEQ_TRIG_BIT];
      cfg_slave   <= RST_SEQ_SETUP[SEQ_SLAVE_BIT];
    end else if (seq_wr) begin
      cfg_enable  <= port.wr_data[SEQ_ENABLE_BIT];
      cfg_rolling <= port.wr_data[SEQ_ROLLING_BIT];
      cfg_trig    <= port.wr_data[SEQ_TRIG_BIT];
      cfg_slave   <= port.wr_data[SEQ_SLAVE_BIT];
    end
  end

  // sequencer controls; trigger and slave only count under global shutter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_enable      <= 1'b0;
      rolling_shutter <= 1'b0;
      triggered_mode  <= 1'b0;
      slave_mode      <= 1'b0;
    end else begin
      seq_enable      <= cfg_enable;
      rolling_shutter <= cfg_rolling;
      triggered_mode  <= cfg_trig & ~cfg_rolling;
      slave_mode      <= cfg_slave & ~cfg_rolling;
    end
  end

  // =====================================================================
  // read multiplexer; unmapped and reserved bits read as zero
  always_comb begin
    next_rd_data = '0;
    case (port.addr)
      OFS_COUNT_LOW: begin
        next_rd_data = snap_count[COUNT_LOW_W-1:0];
      end
      OFS_COUNT_HIGH: begin
        next_rd_data[COUNT_HIGH_W-1:0] = snap_count[COUNT_W-1:COUNT_LOW_W];
      end
      OFS_MEAN_LOCK: begin
        next_rd_data[MEAN_W-1:0] = snap_mean;
        next_rd_data[LOCK_BIT]   = snap_lock;
      end
      OFS_EXPO: begin
        next_rd_data = snap_expo;
      end
      OFS_AMP: begin
        next_rd_data[AMP_A_LSB +: AMP_W]     = snap_amp_a;
        next_rd_data[AMP_B_LSB +: AMP_W]     = snap_amp_b;
        next_rd_data[DGAIN_LSB +: DGAIN_W]   = snap_dgain;
      end
      OFS_SPARE_BD: begin
        next_rd_data = '0;
      end
      OFS_SEQ_SETUP: begin
        next_rd_data[SEQ_ENABLE_BIT]  = cfg_enable;
        next_rd_data[SEQ_ROLLING_BIT] = cfg_rolling;
        next_rd_data[SEQ_TRIG_BIT]    = cfg_trig;
        next_rd_data[SEQ_SLAVE_BIT]   = cfg_slave;
      end
      default: begin
        for (int i = 0; i < SPARE_N; i++) begin
          if (port.addr == SPARE_OFS[i]) begin
            next_rd_data[SPARE_W-1:0] = spare[i];
          end
        end
      end
    endcase
  end

  // read word captured on the read request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port.rd_data <= '0;
    end else if (port.rd_req) begin
      port.rd_data <= next_rd_data;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  count_low_read_a: assert property (
    port.rd_req && port.addr == OFS_COUNT_LOW |=> port.rd_data == $past(snap_count[COUNT_LOW_W-1:0]))
    else $error("sample count low word wrong");
  count_high_read_a: assert property (
    port.rd_req && port.addr == OFS_COUNT_HIGH |=>
      port.rd_data == {13'h0000, $past(snap_count[COUNT_W-1:COUNT_LOW_W])})
    else $error("sample count high word wrong");
  mean_lock_read_a: assert property (
    port.rd_req && port.addr == OFS_MEAN_LOCK |=>
      port.rd_data == {3'h0, $past(snap_lock), 2'h0, $past(snap_mean)})
    else $error("mean and lock word wrong");
  expo_read_a: assert property (
    port.rd_req && port.addr == OFS_EXPO |=> port.rd_data == $past(snap_expo))
    else $error("exposure readback wrong");
  amp_read_a: assert property (
    port.rd_req && port.addr == OFS_AMP |=>
      port.rd_data == {$past(snap_dgain), $past(snap_amp_b), $past(snap_amp_a)})
    else $error("gain readback wrong");
  enable_write_a: assert property (
    seq_wr |-> ##2 seq_enable == $past(port.wr_data[SEQ_ENABLE_BIT], 2))
    else $error("sequencer enable not applied");
  shutter_write_a: assert property (
    seq_wr |-> ##2 rolling_shutter == $past(port.wr_data[SEQ_ROLLING_BIT], 2))
    else $error("shutter select not applied");
  trig_gated_a: assert property (
    seq_wr && port.wr_data[SEQ_ROLLING_BIT] |-> ##2 !triggered_mode [*2])
    else $error("triggered mode active under rolling shutter");
  slave_follow_a: assert property (
    seq_wr && !port.wr_data[SEQ_ROLLING_BIT] |-> ##2 slave_mode == $past(port.wr_data[SEQ_SLAVE_BIT], 2))
    else $error("slave select not applied under global shutter");
  ro_write_drop_a: assert property (
    port.wr_en && port.addr >= OFS_COUNT_LOW && port.addr <= OFS_SPARE_BD |=>
      $stable({cfg_enable, cfg_rolling, cfg_trig, cfg_slave}))
    else $error("read-only write changed setup");

  seq_write_c: cover property (seq_wr ##2 seq_enable);
  mean_read_c: cover property (port.rd_req && port.addr == OFS_MEAN_LOCK);
  trig_mode_c: cover property (triggered_mode && seq_enable);
  slave_mode_c: cover property (slave_mode);
endmodule // aec_seq_regbank
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the exposure readback and sequencer setup register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aec_seq_pkg::*;

  // ======================================================================
  // design signals
  logic                 ref_clk;
  logic                 rst_n;
  logic                 spi_sclk;
  logic                 spi_ss_n;
  logic                 spi_mosi;
  logic                 spi_miso;
  logic                 spi_miso_oe_n;
  logic [COUNT_W-1:0]   aec_sample_count;
  logic [MEAN_W-1:0]    aec_mean;
  logic                 aec_locked;
  logic [EXPO_W-1:0]    aec_exposure;
  logic [AMP_W-1:0]     analog_amp_step_a;
  logic [AMP_W-1:0]     analog_amp_step_b;
  logic [DGAIN_W-1:0]   aec_digital_gain;
  logic                 seq_enable;
  logic                 rolling_shutter;
  logic                 triggered_mode;
  logic                 slave_mode;

  // ======================================================================
  // bench state and reference register image
  localparam logic [ADDR_W-1:0] RO_OFS [5] = '{OFS_COUNT_LOW, OFS_COUNT_HIGH, OFS_MEAN_LOCK, OFS_EXPO, OFS_AMP};
  int                   model [int];
  int                   n_mismatch;
  int                   comparisons;
  logic [DATA_W-1:0]    q;

  aec_seq_regbank i_aec_seq_regbank (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .spi_sclk          (spi_sclk),
    .spi_ss_n          (spi_ss_n),
    .spi_mosi          (spi_mosi),
    .spi_miso          (spi_miso),
    .spi_miso_oe_n     (spi_miso_oe_n),
    .aec_sample_count  (aec_sample_count),
    .aec_mean          (aec_mean),
    .aec_locked        (aec_locked),
    .aec_exposure      (aec_exposure),
    .analog_amp_step_a (analog_amp_step_a),
    .analog_amp_step_b (analog_amp_step_b),
    .aec_digital_gain  (aec_digital_gain),
    .seq_enable        (seq_enable),
    .rolling_shutter   (rolling_shutter),
    .triggered_mode    (triggered_mode),
    .slave_mode        (slave_mode)
  );

  // ======================================================================
  // shared tasks
  // compare one value, count it, report a mismatch
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one 26-bit mode 0 frame, phases of 10 system cycles, miso taken before each of the 16 data-phase rises
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] rd);
    logic [FRAME_BITS-1:0] f;
    f = {a, w, d};
    rd = '0;
    @(negedge ref_clk) spi_ss_n = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      repeat (10) @(negedge ref_clk);
      spi_sclk = 1'b0; // mosi only changes while the clock is low
      spi_mosi = f[i];
      repeat (10) @(negedge ref_clk);
      if (i < DATA_W) rd = {rd[DATA_W-2:0], spi_miso};
      if (i == 0) chk(DATA_W'(spi_miso_oe_n), '0, "miso driven in frame");
      spi_sclk = 1'b1;
    end
    repeat (10) @(negedge ref_clk);
    spi_sclk = 1'b0;
    repeat (10) @(negedge ref_clk);
    spi_ss_n = 1'b1;
    spi_mosi = ~spi_mosi;
    repeat (10) @(negedge ref_clk);
    chk(DATA_W'(spi_miso_oe_n), 16'h0001, "miso released after frame");
  endtask

  // new random exposure loop status and its expected readback words
  task automatic new_status();
    @(negedge ref_clk);
    aec_sample_count  = COUNT_W'($urandom);
    aec_mean          = MEAN_W'($urandom);
    aec_locked        = 1'($urandom);
    aec_exposure      = EXPO_W'($urandom);
    analog_amp_step_a = AMP_W'($urandom);
    analog_amp_step_b = AMP_W'($urandom);
    aec_digital_gain  = DGAIN_W'($urandom);
    model[int'(OFS_COUNT_LOW)]  = int'(aec_sample_count) & 'hFFFF;
    model[int'(OFS_COUNT_HIGH)] = (int'(aec_sample_count) >> 16) & 'h7;
    model[int'(OFS_MEAN_LOCK)]  = int'(aec_mean) | (int'(aec_locked) << 12);
    model[int'(OFS_EXPO)]       = int'(aec_exposure);
    model[int'(OFS_AMP)] = int'(analog_amp_step_a) | (int'(analog_amp_step_b) << 2) | (int'(aec_digital_gain) << 4);
  endtask

  // read the five read-only status words and compare with the image
  task automatic check_status();
    for (int i = 0; i < 5; i++) begin
      xfer(RO_OFS[i], 1'b0, '0, q);
      chk(q, DATA_W'(model[int'(RO_OFS[i])]), "status word"); // readback
    end
  endtask

  // print counts and the verdict, then stop
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ======================================================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // about 80000 cycles, well beyond the expected run
  initial begin
    #400000;
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ======================================================================
  // main sequence
  initial begin
    int d;
    int e;
    rst_n = 1'b0;
    spi_sclk = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
    aec_sample_count = '0;
    aec_mean = '0;
    aec_locked = 1'b0;
    aec_exposure = '0;
    analog_amp_step_a = '0;
    analog_amp_step_b = '0;
    aec_digital_gain = '0;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(32'h27d3));
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);

    // reset values of setup, spares, the spare bd word and an unmapped offset
    chk({12'h0, slave_mode, triggered_mode, rolling_shutter, seq_enable}, '0, "reset outputs"); // idle
    xfer(OFS_SEQ_SETUP, 1'b0, '0, q);
    chk(q, RST_SEQ_SETUP, "setup reset"); // setup default
    for (int i = 0; i < SPARE_N; i++) begin
      xfer(SPARE_OFS[i], 1'b0, '0, q);
      chk(q, DATA_W'(SPARE_RST[i]), "spare reset");
    end
    xfer(OFS_SPARE_BD, 1'b0, '0, q);
    chk(q, '0, "spare bd");
    xfer(9'h1FF, 1'b0, '0, q);
    chk(q, '0, "unmapped read");
    $display("test reset values done");

    // spare words keep what is written, ten bits wide
    for (int i = 0; i < SPARE_N; i++) begin
      d = $urandom & 'hFFFF;
      xfer(SPARE_OFS[i], 1'b1, DATA_W'(d), q);
      xfer(SPARE_OFS[i], 1'b0, '0, q);
      chk(q, DATA_W'(d & 'h3FF), "spare write");
    end
    $display("test spare words done");

    // random status readback
    repeat (3) begin
      new_status();
      check_status();
    end
    $display("test status readback done");

    // writes to read-only words change nothing
    for (int i = 0; i < 5; i++) begin
      xfer(RO_OFS[i], 1'b1, DATA_W'($urandom), q);
    end
    check_status(); // unchanged after writes
    $display("test read-only writes done");

    // every combination of enable, rolling, trigger and slave
    for (int c = 0; c < 16; c++) begin
      d = ($urandom & 'hFFCC) | (c & 'h3) | ((c & 'hC) << 2);
      model[int'(OFS_SEQ_SETUP)] = d & 'h33;
      e = (c & 'h3) | ((c & 'h4) != 0 && (c & 'h2) == 0 ? 4 : 0) | ((c & 'h8) != 0 && (c & 'h2) == 0 ? 8 : 0);
      xfer(OFS_SEQ_SETUP, 1'b1, DATA_W'(d), q);
      chk({12'h0, slave_mode, triggered_mode, rolling_shutter, seq_enable}, DATA_W'(e), "setup outputs");
      xfer(OFS_SEQ_SETUP, 1'b0, '0, q);
      chk(q, DATA_W'(model[int'(OFS_SEQ_SETUP)]), "setup readback"); // stored bits
    end
    $display("test sequencer setup done");

    // reset in mid-run returns the setup word to idle global shutter
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk({12'h0, slave_mode, triggered_mode, rolling_shutter, seq_enable}, '0, "outputs after reset");
    xfer(OFS_SEQ_SETUP, 1'b0, '0, q);
    chk(q, RST_SEQ_SETUP, "setup after reset");
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
